// ==== hw/pll_clock_generator_control.sv ====
// Operation
// RULE1: Oscillator runs on enable or keep-in-stop bit
// RULE2: Reference clock is buffered crystal clock
// RULE3: Feedback divider divides VCO clock by N
// RULE4: Phase detector emits up/down correction pulses
// RULE5: Lock detector compares frequencies per reference window
// RULE6: Acquisition mode reads tracking bit clear
// RULE7: Tracking mode whenever tracking bit set
// RULE8: Auto mode: lock detector switches filter mode
// RULE9: Auto mode: tracking bit read-only, follows tolerance
// RULE10: Auto mode: settled bit read-only, follows tolerance
// RULE11: Auto with enable: interrupt on settled change
// RULE12: Manual mode: tracking bit software writable
// RULE13: Software clears tracking bit before power-on
// RULE14: Software waits acquisition time before tracking
// RULE15: Software waits lock time before VCO select
// RULE16: Manual mode: no settled bit, no interrupt
// RULE17: Software selects VCO only when settled
// RULE18: VCO is N times reference; bus quarter
// RULE19: Software picks E by VCO range, never 3
// RULE20: Center frequency is L times 2^E times nominal
// RULE21: Multiplier zero behaves as one
// RULE22: Linear factor zero disables synthesizer, forces crystal
// RULE23: Refuse unsafe power and selection changes
// RULE24: Hold output across switch, then divide by two
// RULE25: Lock detector status synchronised before use
//
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/10ps
`include "pll_cgm_regs.svh"
module pll_clock_generator_control (
    // Clock and reset
    input  wire logic                    ref_clk,
    input  wire logic                    rst_n,
    // Register port
    input  wire pll_cgm_pkg::bus_req_t   bus_req,
    output      logic [7:0]              rdata,
    // Integration module and analog clocks
    input  wire logic                    integration_osc_enable,
    input  wire logic                    crystal_clock,
    input  wire logic                    vco_clock,
    // Oscillator and synthesizer controls
    output      logic                    crystal_osc_run,
    output      logic                    vco_enable,
    output      logic [31:0]             vco_center_hz,
    output      logic                    filter_tracking_mode,
    // Derived clocks and correction pulse
    output      logic                    reference_clock,
    output      logic                    final_reference_clock,
    output      logic                    feedback_divided_clock,
    output      pll_cgm_pkg::pump_t      pump,
    // Base clock and interrupt
    output      logic                    base_clock_out,
    output      logic                    base_clock_is_vco,
    output      logic                    settle_irq
);
    import pll_cgm_pkg::*;

    ctrl_t         ctrl_reg;          // Software control fields
    logic          auto_reg;          // Automatic bandwidth mode
    logic          track_manual_reg;  // Software tracking choice in manual mode
    logic [11:0]   mult_reg;          // Multiplier N
    logic [7:0]    lin_reg;           // Linear factor L
    logic          lock_reg;          // Frequency-settled bit
    logic          irq_flag_reg;      // Pending settle interrupt
    logic [1:0]    clk_s;             // Synchronised crystal and VCO clocks
    logic [1:0]    clk_prev_reg;      // Previous synchronised levels
    logic          xtal_edge;         // Crystal rising edge
    logic          vco_edge;          // VCO rising edge
    logic [11:0]   n_eff;             // Effective divide ratio
    logic [11:0]   div_cnt_reg;       // Feedback divider count
    logic [7:0]    win_cnt_reg;       // Reference edges in window
    logic [7:0]    fb_cnt_reg;        // Feedback edges in window
    logic          in_tol_raw_reg;    // Detector verdict, slow side
    logic          in_tol_s;          // Verdict after synchroniser
    logic          track_bit;         // Tracking status as seen by software
    logic          target_vco;        // Requested and allowed VCO selection
    switch_state_t sw_state_reg;      // Base clock switch state
    logic [1:0]    xtal_wait_reg;     // Crystal edges seen during switch
    logic [1:0]    vco_wait_reg;      // VCO edges seen during switch
    logic          sel_edge;          // Edge of the selected source
    logic          wr_ctrl;           // Control register write
    logic          rd_ctrl;           // Control register read
    logic          power_change;      // Write would toggle power
    logic          choice_change;     // Write would toggle selection

    // Both pin clocks cross in from outside the ref_clk domain
    clock_sync_cell #(.WIDTH(2)) u_clk_sync (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .async_in ({vco_clock, crystal_clock}),
        .sync_out (clk_s)
    );

    // Detector verdict passes a synchroniser before status or interrupt use it
    clock_sync_cell #(.WIDTH(1)) u_lock_sync (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .async_in (in_tol_raw_reg),
        .sync_out (in_tol_s)                              // RULE25
    );

    assign xtal_edge     = clk_s[0] & ~clk_prev_reg[0];
    assign vco_edge      = clk_s[1] & ~clk_prev_reg[1];
    assign n_eff         = (mult_reg == 12'h000) ? 12'h001 : mult_reg;   // RULE21
    assign track_bit     = auto_reg ? in_tol_s : track_manual_reg;       // RULE8 RULE9 RULE12
    assign target_vco    = ctrl_reg.choice & ctrl_reg.power_on & (lin_reg != 8'h00); // RULE22
    assign sel_edge      = base_clock_is_vco ? vco_edge : xtal_edge;
    assign wr_ctrl       = bus_req.we & (bus_req.addr == `CGM_ADDR_CTRL);
    assign rd_ctrl       = bus_req.re & (bus_req.addr == `CGM_ADDR_CTRL);
    assign power_change  = bus_req.wdata[`CGM_CTRL_POWER] != ctrl_reg.power_on;
    assign choice_change = bus_req.wdata[`CGM_CTRL_CHOICE] != ctrl_reg.choice;

    // Edge history for the synchronised clocks
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            clk_prev_reg <= 2'h0;
        else
            clk_prev_reg <= clk_s;
    end

    // Control register, with interlocks on power and selection
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            ctrl_reg <= '0;
        else if (wr_ctrl)
        begin
            ctrl_reg.irq_en    <= bus_req.wdata[`CGM_CTRL_IRQ_EN];
            ctrl_reg.keep_stop <= bus_req.wdata[`CGM_CTRL_KEEP];
            ctrl_reg.range_e   <= bus_req.wdata[1:0];
            // A joint change of both bits is dropped whole
            if (!(power_change && choice_change))                        // RULE23
            begin
                // Power may not drop while the VCO is chosen
                if (!(ctrl_reg.choice && !bus_req.wdata[`CGM_CTRL_POWER])) // RULE23
                    ctrl_reg.power_on <= bus_req.wdata[`CGM_CTRL_POWER];
                // VCO may not be chosen while power is off
                if (!(bus_req.wdata[`CGM_CTRL_CHOICE] && !ctrl_reg.power_on)) // RULE23
                    ctrl_reg.choice <= bus_req.wdata[`CGM_CTRL_CHOICE];
            end
        end
    end

    // Bandwidth register: mode bit and manual tracking choice
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            auto_reg         <= `CGM_AUTO_RST;
            track_manual_reg <= 1'b0;
        end
        else if (bus_req.we && bus_req.addr == `CGM_ADDR_BW)
        begin
            auto_reg <= bus_req.wdata[`CGM_BW_AUTO];
            // Only honoured when the write leaves the block in manual mode
            if (!bus_req.wdata[`CGM_BW_AUTO])
                track_manual_reg <= bus_req.wdata[`CGM_BW_TRACK];        // RULE12
        end
    end

    // Multiplier and linear factor
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mult_reg <= `CGM_MUL_RST;
            lin_reg  <= `CGM_LIN_RST;
        end
        else if (bus_req.we)
        begin
            case (bus_req.addr)
                `CGM_ADDR_MUL_LO: mult_reg[7:0]  <= bus_req.wdata;
                `CGM_ADDR_MUL_HI: mult_reg[11:8] <= bus_req.wdata[3:0];
                `CGM_ADDR_RANGE:  lin_reg        <= bus_req.wdata;
                default:          mult_reg       <= mult_reg;
            endcase
        end
    end

    // Read data one cycle after the strobe; unmapped reads return zero
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            rdata <= 8'h00;
        else if (bus_req.re)
        begin
            case (bus_req.addr)
                `CGM_ADDR_CTRL:   rdata <= {ctrl_reg.irq_en, irq_flag_reg, ctrl_reg.power_on,
                                            ctrl_reg.choice, ctrl_reg.keep_stop, 1'b0, ctrl_reg.range_e};
                `CGM_ADDR_BW:     rdata <= {auto_reg, lock_reg, track_bit, 5'h00};   // RULE6 RULE10
                `CGM_ADDR_MUL_LO: rdata <= mult_reg[7:0];
                `CGM_ADDR_MUL_HI: rdata <= {4'h0, mult_reg[11:8]};
                `CGM_ADDR_RANGE:  rdata <= lin_reg;
                default:          rdata <= 8'h00;
            endcase
        end
    end

    // Oscillator enable and synthesizer power
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            crystal_osc_run <= 1'b0;
            vco_enable      <= 1'b0;
        end
        else
        begin
            crystal_osc_run <= integration_osc_enable | ctrl_reg.keep_stop;  // RULE1
            vco_enable      <= ctrl_reg.power_on & (lin_reg != 8'h00);       // RULE22
        end
    end

    // Programmed center frequency; E of 3 is left to software to avoid
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            vco_center_hz <= 32'h00000000;
        else
            vco_center_hz <= 32'(({24'h000000, lin_reg} << ctrl_reg.range_e) * `CGM_NOM_CENTER_HZ); // RULE20
    end

    // Buffered reference copies; no reference predivider in this block
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reference_clock       <= 1'b0;
            final_reference_clock <= 1'b0;
        end
        else
        begin
            reference_clock       <= clk_s[0];                           // RULE2
            final_reference_clock <= clk_s[0];
        end
    end

    // Modulo-N feedback divider: one strobe every N VCO edges
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            div_cnt_reg            <= 12'h000;
            feedback_divided_clock <= 1'b0;
        end
        else
        begin
            feedback_divided_clock <= 1'b0;
            if (vco_edge)
            begin
                if (div_cnt_reg >= n_eff - 12'h001)                      // RULE3
                begin
                    div_cnt_reg            <= 12'h000;
                    feedback_divided_clock <= 1'b1;
                end
                else
                    div_cnt_reg <= div_cnt_reg + 12'h001;
            end
        end
    end

    // Phase-frequency detector; whichever edge leads opens the pulse
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            pump <= '0;
        else if ((pump.up || xtal_edge) && (pump.down || feedback_divided_clock))
            pump <= '0;                                                  // RULE4
        else
        begin
            if (xtal_edge)
                pump.up <= 1'b1;
            if (feedback_divided_clock)
                pump.down <= 1'b1;
        end
    end

    // Frequency lock detector: window length set in reference edges
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            win_cnt_reg    <= 8'h00;
            fb_cnt_reg     <= 8'h00;
            in_tol_raw_reg <= 1'b0;
        end
        else if (!vco_enable)
        begin
            win_cnt_reg    <= 8'h00;
            fb_cnt_reg     <= 8'h00;
            in_tol_raw_reg <= 1'b0;
        end
        else
        begin
            if (xtal_edge && win_cnt_reg == `CGM_LOCK_WINDOW - 8'h01)
            begin
                // Window closes: feedback count must match within tolerance
                win_cnt_reg    <= 8'h00;
                fb_cnt_reg     <= {7'h00, feedback_divided_clock};
                in_tol_raw_reg <= (fb_cnt_reg + `CGM_LOCK_TOL >= `CGM_LOCK_WINDOW) &&
                                  (fb_cnt_reg <= `CGM_LOCK_WINDOW + `CGM_LOCK_TOL); // RULE5
            end
            else
            begin
                if (xtal_edge)
                    win_cnt_reg <= win_cnt_reg + 8'h01;
                // Saturate so a runaway VCO cannot wrap into tolerance
                if (feedback_divided_clock && fb_cnt_reg != 8'hFF)
                    fb_cnt_reg <= fb_cnt_reg + 8'h01;
            end
        end
    end

    // Filter mode drive and settled bit
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            filter_tracking_mode <= 1'b0;
            lock_reg             <= 1'b0;
        end
        else
        begin
            filter_tracking_mode <= track_bit;                           // RULE7
            lock_reg             <= auto_reg & in_tol_s;                 // RULE10 RULE16
        end
    end

    // Settle interrupt: set on each settled change, cleared by reading control
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            irq_flag_reg <= 1'b0;
        else if (auto_reg && ctrl_reg.irq_en && (lock_reg != (auto_reg & in_tol_s)))
            irq_flag_reg <= 1'b1;                                        // RULE11
        else if (rd_ctrl || !auto_reg)
            irq_flag_reg <= 1'b0;                                        // RULE16
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            settle_irq <= 1'b0;
        else
            settle_irq <= irq_flag_reg & ctrl_reg.irq_en & auto_reg;
    end

    // Base clock switch: hold output, wait on the crystal and on a powered VCO, then swap
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sw_state_reg      <= SW_RUN;
            xtal_wait_reg     <= 2'h0;
            vco_wait_reg      <= 2'h0;
            base_clock_is_vco <= 1'b0;
        end
        else
        begin
            case (sw_state_reg)
                SW_RUN:
                begin
                    if (target_vco != base_clock_is_vco)
                    begin
                        sw_state_reg  <= SW_WAIT;
                        xtal_wait_reg <= 2'h0;
                        vco_wait_reg  <= 2'h0;
                    end
                end
                SW_WAIT:
                begin
                    if (xtal_edge && xtal_wait_reg != `CGM_SWITCH_EDGES)
                        xtal_wait_reg <= xtal_wait_reg + 2'h1;
                    if (vco_edge && vco_wait_reg != `CGM_SWITCH_EDGES)
                        vco_wait_reg <= vco_wait_reg + 2'h1;
                    // A powered-down VCO gives no edges, so it is not waited on
                    if (xtal_wait_reg == `CGM_SWITCH_EDGES &&
                        (vco_wait_reg == `CGM_SWITCH_EDGES || !vco_enable)) // RULE24
                    begin
                        base_clock_is_vco <= target_vco;                 // RULE22
                        sw_state_reg      <= SW_RUN;
                    end
                end
                default: sw_state_reg <= SW_RUN;
            endcase
        end
    end

    // Divide the chosen source by two; frozen while switching
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            base_clock_out <= 1'b0;
        else if (sw_state_reg == SW_RUN && sel_edge)
            base_clock_out <= ~base_clock_out;                           // RULE18 RULE24
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence s_switch_start;
        sw_state_reg == SW_RUN && target_vco != base_clock_is_vco;
    endsequence
    sequence s_switch_hold;
        $stable(base_clock_out) throughout (sw_state_reg == SW_WAIT)[*2];
    endsequence

    property p_osc_run;
        integration_osc_enable || ctrl_reg.keep_stop |=> crystal_osc_run;
    endproperty
    a_osc_run: assert property (p_osc_run) else $error("oscillator not running when enabled"); // RULE1

    property p_ref_copy;
        ##2 reference_clock == $past(clk_s[0]);
    endproperty
    a_ref_copy: assert property (p_ref_copy) else $error("reference clock not crystal copy"); // RULE2

    property p_div_range;
        // A shorter N only takes hold at the next VCO edge, so check just after one
        vco_edge |=> div_cnt_reg < $past(n_eff);
    endproperty
    a_div_range: assert property (p_div_range) else $error("divider count beyond N"); // RULE3

    property p_pump_excl;
        !(pump.up && pump.down);
    endproperty
    a_pump_excl: assert property (p_pump_excl) else $error("both correction pulses high"); // RULE4

    property p_manual_quiet;
        !auto_reg ##1 !auto_reg |-> !lock_reg && !settle_irq;
    endproperty
    a_manual_quiet: assert property (p_manual_quiet) else $error("settled or irq in manual mode"); // RULE16

    property p_irq_on_change;
        auto_reg && ctrl_reg.irq_en && $changed(lock_reg) && $past(auto_reg) |-> ##[1:2] settle_irq;
    endproperty
    a_irq_on_change: assert property (p_irq_on_change) else $error("no irq on settled change"); // RULE11

    property p_no_vco_unpowered;
        ctrl_reg.choice |-> ctrl_reg.power_on;
    endproperty
    a_no_vco_unpowered: assert property (p_no_vco_unpowered) else $error("VCO chosen while off"); // RULE23

    property p_lzero_crystal;
        lin_reg == 8'h00 && !base_clock_is_vco |=> !base_clock_is_vco;
    endproperty
    a_lzero_crystal: assert property (p_lzero_crystal) else $error("VCO used with L zero"); // RULE22

    property p_switch_hold;
        // The RUN cycle may still launch one toggle, so the hold starts a cycle later
        s_switch_start |=> ##1 s_switch_hold;
    endproperty
    a_switch_hold: assert property (p_switch_hold) else $error("base clock moved during switch"); // RULE24

    property p_track_follow;
        ##1 filter_tracking_mode == $past(track_bit);
    endproperty
    a_track_follow: assert property (p_track_follow) else $error("filter mode not tracking bit"); // RULE7

endmodule

// ==== include/pll_cgm_regs.svh ====
`ifndef PLL_CGM_REGS_SVH
`define PLL_CGM_REGS_SVH

// Register indices on the plain register port
`define CGM_ADDR_CTRL     3'h0
`define CGM_ADDR_BW       3'h1
`define CGM_ADDR_MUL_LO   3'h2
`define CGM_ADDR_MUL_HI   3'h3
`define CGM_ADDR_RANGE    3'h4

// Field positions in the control register
`define CGM_CTRL_IRQ_EN   7
`define CGM_CTRL_IRQ_FLAG 6
`define CGM_CTRL_POWER    5
`define CGM_CTRL_CHOICE   4
`define CGM_CTRL_KEEP     3

// Field positions in the bandwidth register
`define CGM_BW_AUTO       7
`define CGM_BW_LOCK       6
`define CGM_BW_TRACK      5

// Reset values
`define CGM_MUL_RST       12'h040
`define CGM_LIN_RST       8'h40
`define CGM_AUTO_RST      1'h0

// Nominal VCO center frequency in Hz (71.4 kHz)
`define CGM_NOM_CENTER_HZ 32'h000116E8

// Lock detector: reference edges per window, and allowed feedback count error
`define CGM_LOCK_WINDOW   8'h10
`define CGM_LOCK_TOL      8'h01

// Source edges to wait on each clock during a base clock change
`define CGM_SWITCH_EDGES  2'h3

`endif

// ==== include/pll_cgm_pkg.sv ====
package pll_cgm_pkg;

    // Software control fields
    typedef struct packed {
        logic       irq_en;
        logic       power_on;
        logic       choice;
        logic       keep_stop;
        logic [1:0] range_e;
    } ctrl_t;

    // Register port request
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       we;
        logic       re;
    } bus_req_t;

    // Phase detector correction pulse
    typedef struct packed {
        logic up;
        logic down;
    } pump_t;

    // Base clock switch states
    typedef enum logic [0:0] {
        SW_RUN  = 1'b0,
        SW_WAIT = 1'b1
    } switch_state_t;

endpackage

// ==== hw/clock_sync_cell.sv ====
`timescale 1ns/10ps
module clock_sync_cell #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    // Asynchronous input and synchronised output
    input  wire logic [WIDTH-1:0] async_in,
    output      logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1_reg;   // Read only by the second stage

    // Two flops to settle metastability
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stage1_reg <= '0;
            sync_out   <= '0;
        end
        else
        begin
            stage1_reg <= async_in;
            sync_out   <= stage1_reg;
        end
    end

endmodule

// ==== tb/clock_source_model.sv ====
`timescale 1ns/10ps
module clock_source_model #(
    parameter real XTAL_HALF = 40.0,
    parameter real VCO_HALF  = 40.0
) (
    // Enables from the block
    input  wire logic osc_run,
    input  wire logic vco_on,
    // Clocks toward the block
    output      logic xtal,
    output      logic vco
);
    // Crystal stands still unless the block keeps it running
    initial xtal = 1'b0;
    always #(XTAL_HALF) if (osc_run) xtal = ~xtal;
    // VCO stands still while the synthesizer is off
    initial vco = 1'b0;
    always #(VCO_HALF) if (vco_on) vco = ~vco;
endmodule

// ==== tb/tb_pll_clock_generator_control.sv ====
`timescale 1ns/10ps
module tb_pll_clock_generator_control;
    import pll_cgm_pkg::*;
    // Clock, reset, register port
    logic        ref_clk = 1'b0;
    logic        rst_n   = 1'b0;
    bus_req_t    bus_req = '0;
    logic [7:0]  rdata;
    // Far side and observed outputs
    logic        osc_en  = 1'b1;
    logic        xtal, vco, run, ven, trk, rclk, frclk, fb, bco, isv, irq, bq;
    logic [31:0] ctr;
    pump_t       pump;
    // Counters; edge counts are loose since pins cross a synchroniser
    int          n_mismatch = 0, cmp_count = 0, cyc = 0, vc, xc, tc, fc, rc, rf;
    logic [31:0] seed = 32'hD4FA;
    logic        cnt  = 1'b0;

    clock_source_model u_src (.osc_run(run), .vco_on(ven), .xtal(xtal), .vco(vco));
    pll_clock_generator_control u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .bus_req(bus_req),
        .rdata(rdata), .integration_osc_enable(osc_en), .crystal_clock(xtal), .vco_clock(vco),
        .crystal_osc_run(run), .vco_enable(ven), .vco_center_hz(ctr), .filter_tracking_mode(trk),
        .reference_clock(rclk), .final_reference_clock(frclk), .feedback_divided_clock(fb),
        .pump(pump), .base_clock_out(bco), .base_clock_is_vco(isv), .settle_irq(irq));

    // Clock and edge bookkeeping
    always #2.5 ref_clk = ~ref_clk;
    always @(posedge vco) if (cnt) vc++;
    always @(posedge xtal) if (cnt) xc++;
    always @(posedge rclk) if (cnt) rc++;
    always @(posedge frclk) if (cnt) rf++;
    always @(posedge ref_clk)
    begin
        cyc++;
        bq <= bco;
        if (cnt && fb === 1'b1) fc++;
        if (cnt && bco !== bq) tc++;
        if (rst_n) chk("pump excl", 32'h0, {31'h0, pump.up & pump.down});
        if (cyc == 40000)
        begin
            n_mismatch++;
            wrap_up();
        end
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    function automatic logic [31:0] near(input int a, input int b);
        return 32'((a - b <= 2) && (b - a <= 2));
    endfunction

    task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        bus_req <= '{a, d, 1'b1, 1'b0};
        @(posedge ref_clk);
        bus_req <= '0;
        repeat (2) @(posedge ref_clk);
    endtask
    task automatic rd(input string w, input logic [2:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        bus_req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge ref_clk);
        bus_req <= '0;
        #1 chk(w, {24'h0, e}, {24'h0, rdata});
    endtask
    task automatic win(input int n);
        {vc, xc, tc, fc, rc, rf} = 192'h0;
        cnt = 1'b1;
        repeat (n) @(posedge ref_clk);
        cnt = 1'b0;
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd("ctrl", 3'h0, 8'h00);
        rd("mul_lo", 3'h2, 8'h40);
        rd("lin", 3'h4, 8'h40);
        rd("unmapped", 3'h6, 8'h00);
        // Oscillator stays up through keep bit alone
        osc_en <= 1'b0;
        wr(3'h0, 8'h00);
        chk("osc off", 32'h0, 32'(run));
        wr(3'h0, 8'h08);
        chk("osc keep", 32'h1, 32'(run));
        osc_en <= 1'b1;
        // Unsafe control writes are dropped
        wr(3'h0, 8'h18);
        rd("sel off", 3'h0, 8'h08);
        wr(3'h0, 8'h38);
        rd("both", 3'h0, 8'h08);
        $display("test osc/refuse done");
        // Center frequency over random L and E, L zero first
        for (int i = 0; i < 6; i++)
        begin
            seed = xs(seed);
            if (i == 0) seed[7:0] = 8'h00;
            if (seed[9:8] == 2'h3) seed[9:8] = 2'h2;
            wr(3'h4, seed[7:0]);
            wr(3'h0, {6'h00, seed[9:8]});
            chk("center", ({24'h0, seed[7:0]} << seed[9:8]) * `CGM_NOM_CENTER_HZ, ctr);
        end
        wr(3'h4, 8'h00);
        wr(3'h0, 8'h20);
        wr(3'h0, 8'h30);
        repeat (200) @(posedge ref_clk);
        chk("l0 ven", 32'h0, 32'(ven));
        chk("l0 sel", 32'h0, 32'(isv));
        wr(3'h0, 8'h20);
        wr(3'h4, 8'h40);
        chk("ven", 32'h1, 32'(ven));
        // Manual tracking bit, no settle indication
        wr(3'h1, 8'h20);
        chk("trk", 32'h1, 32'(trk));
        rd("bw man", 3'h1, 8'h20);
        wr(3'h1, 8'h00);
        chk("acq", 32'h0, 32'(trk));
        // Divider by four, then zero acting as one
        wr(3'h2, 8'h04);
        win(2000);
        chk("div4", 32'h1, near(fc, vc / 4));
        wr(3'h2, 8'h00);
        win(1000);
        chk("div0", 32'h1, near(fc, vc));
        $display("test divider done");
        // Auto mode: lock, interrupt, then loss of lock
        wr(3'h2, 8'h01);
        wr(3'h0, 8'hA0);
        wr(3'h1, 8'hA0);
        repeat (800) @(posedge ref_clk);
        rd("bw lock", 3'h1, 8'hE0);
        chk("irq set", 32'h1, 32'(irq));
        rd("ctrl flag", 3'h0, 8'hE0);
        repeat (2) @(posedge ref_clk);
        chk("irq clr", 32'h0, 32'(irq));
        wr(3'h2, 8'h02);
        repeat (800) @(posedge ref_clk);
        rd("bw lost", 3'h1, 8'h80);
        chk("irq lost", 32'h1, 32'(irq));
        wr(3'h1, 8'h00);
        chk("irq man", 32'h0, 32'(irq));
        rd("bw man2", 3'h1, 8'h00);
        $display("test auto done");
        // Base clock from crystal, then from VCO
        wr(3'h2, 8'h01);
        wr(3'h1, 8'h20);
        win(2000);
        chk("bco xtal", 32'h1, near(tc, xc));
        chk("ref copy", 32'h1, near(rc, xc));
        chk("final ref", 32'h1, near(rf, xc));
        wr(3'h0, 8'h30);
        repeat (200) @(posedge ref_clk);
        chk("sel vco", 32'h1, 32'(isv));
        wr(3'h0, 8'h10);
        rd("off refused", 3'h0, 8'h30);
        win(2000);
        chk("bco vco", 32'h1, near(tc, vc));
        $display("test base clock done");
        wrap_up();
    end
endmodule
